// ==== hdl/boot_grant_pkg.sv ====
// Constants and carrier types for the boot selection and bus grant block.
// Assumes a single processor clock and a synchronous active high reset.
package boot_grant_pkg;
	localparam logic [2:0] MODE_BYTE_FULL = 3'h0;
	localparam logic [2:0] MODE_NO_BOOT = 3'h2;
	localparam logic [2:0] MODE_BYTE_HOST = 3'h4;
	localparam logic [2:0] MODE_HOST_PORT = 3'h5;
	localparam int COUNT_WIDTH = 14;
	localparam logic [13:0] BOOT_WORD_COUNT = 14'h0020;
	localparam logic [13:0] COUNT_RESET = 14'h0000;
	localparam logic [7:0] PAGE_RESET = 8'h00;
	localparam logic [13:0] ADDR_RESET = 14'h0000;
	localparam logic [1:0] FORMAT_RESET = 2'h0;
	localparam logic [2:0] PIN_SYNC_RESET = 3'h0;

	typedef struct packed {
		logic direction;
		logic [7:0] page;
		logic [13:0] internal_start;
		logic [13:0] external_start;
		logic [1:0] word_format;
		logic context_reset;
	} byte_dma_setup_type;

	typedef struct packed {
		logic prog_mem_select_n;
		logic data_mem_select_n;
		logic byte_mem_select_n;
		logic composite_select_n;
		logic io_space_select_n;
		logic rd_n;
		logic wr_n;
	} strobes_type;

	typedef enum {
		ST_RESET,
		ST_BYTE_BOOT,
		ST_HOST_WAIT,
		ST_RUN
	} boot_state_type;
endpackage

// ==== hdl/boot_select_and_bus_grant.sv ====
// Boot method selection after reset and external bus request and grant.
// Assumes the core drives access and byte DMA strobes on i_clock; pins are asynchronous.
`timescale 1ns/1ps
module boot_select_and_bus_grant (
	// Clock and reset.
	input wire logic i_clock,
	input wire logic i_sys_rst,
	// Configuration pins, C B A.
	input wire logic [2:0] i_mode_pins,
	// External bus master handshake.
	input wire logic i_ext_bus_req_n,
	output logic o_ext_bus_grant_n,
	output logic o_grant_hang_n,
	// Core side access status.
	input wire logic i_ext_access_busy,
	input wire logic i_ext_access_wanted,
	input wire logic i_run_until_external,
	input wire logic i_core_ready,
	// Core memory strobes and their drive enables.
	input wire boot_grant_pkg::strobes_type i_core_strobes,
	input wire logic i_core_bus_drive,
	output boot_grant_pkg::strobes_type o_strobes,
	output logic o_strobes_oe,
	output logic o_bus_oe,
	// Byte DMA word transfers and program memory writes.
	input wire logic i_byte_dma_word_done,
	input wire logic i_byte_dma_addr_lsb,
	input wire logic i_pm0_written,
	output logic [13:0] o_byte_dma_word_count,
	output boot_grant_pkg::byte_dma_setup_type o_byte_dma_setup,
	output logic o_byte_dma_active,
	output logic o_byte_dma_done_irq,
	output logic o_byte_addr_lsb,
	output logic o_byte_addr_lsb_oe,
	// Boot and execution results.
	output logic o_host_mode,
	output logic o_exec_hold,
	output logic o_context_clear,
	output logic o_core_halt
);
	logic [2:0] mode_s1_r, mode_s2_r, mode_s3_r;
	logic [2:0] req_sync_r;
	logic req_r;
	logic rst_d_r;
	logic [2:0] mode_r;
	boot_grant_pkg::boot_state_type state_r, state_nxt;
	logic [13:0] count_r;
	boot_grant_pkg::byte_dma_setup_type setup_r;
	logic granted_r;
	logic hang_r;
	logic halt_r;
	logic hold_r;
	logic host_r;
	logic irq_r;
	logic ctx_r;
	boot_grant_pkg::strobes_type strobes_r;
	logic strobes_oe_r, bus_oe_r, lsb_r, lsb_oe_r;
	logic release_edge;
	logic grant_ok;

	function automatic logic is_byte_boot(input logic [2:0] m);
		is_byte_boot = (m == boot_grant_pkg::MODE_BYTE_FULL) || (m == boot_grant_pkg::MODE_BYTE_HOST);
	endfunction

	// Pin synchronisers; the request bit only counts once stages two and three agree, the mode bits are taken from stage two.
	always_ff @(posedge i_clock) begin
		mode_s1_r <= i_mode_pins;
		mode_s2_r <= mode_s1_r;
		mode_s3_r <= mode_s2_r;
		req_sync_r <= {req_sync_r[1:0], ~i_ext_bus_req_n};
	end

	always_ff @(posedge i_clock) begin
		if (req_sync_r[1] == req_sync_r[2]) begin
			req_r <= req_sync_r[2];
		end
	end

	// Reset release detection and mode capture.
	always_ff @(posedge i_clock) begin
		rst_d_r <= i_sys_rst;
	end
	assign release_edge = rst_d_r && !i_sys_rst;

	always_ff @(posedge i_clock) begin
		if (release_edge && (mode_s2_r == mode_s3_r)) begin
			mode_r <= mode_s3_r;
		end else if (release_edge) begin
			mode_r <= mode_s2_r;
		end
	end

	// Boot sequencing.
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			boot_grant_pkg::ST_RESET: begin
				if (release_edge) begin
					if (is_byte_boot(mode_s2_r)) begin
						state_nxt = boot_grant_pkg::ST_BYTE_BOOT;
					end else if (mode_s2_r == boot_grant_pkg::MODE_HOST_PORT) begin
						state_nxt = boot_grant_pkg::ST_HOST_WAIT;
					end else begin
						state_nxt = boot_grant_pkg::ST_RUN;
					end
				end
			end
			boot_grant_pkg::ST_BYTE_BOOT: begin
				if (i_byte_dma_word_done && (count_r == 14'h0001)) begin
					state_nxt = boot_grant_pkg::ST_RUN;
				end
			end
			boot_grant_pkg::ST_HOST_WAIT: begin
				if (i_pm0_written) begin
					state_nxt = boot_grant_pkg::ST_RUN;
				end
			end
			boot_grant_pkg::ST_RUN: begin
				state_nxt = boot_grant_pkg::ST_RUN;
			end
			default: begin
				state_nxt = boot_grant_pkg::ST_RESET;
			end
		endcase
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			state_r <= boot_grant_pkg::ST_RESET;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Byte DMA setup and word count.
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			setup_r.direction <= 1'b0;
			setup_r.page <= boot_grant_pkg::PAGE_RESET;
			setup_r.internal_start <= boot_grant_pkg::ADDR_RESET;
			setup_r.external_start <= boot_grant_pkg::ADDR_RESET;
			setup_r.word_format <= boot_grant_pkg::FORMAT_RESET;
			setup_r.context_reset <= is_byte_boot(mode_s2_r);
		end else if (state_r == boot_grant_pkg::ST_BYTE_BOOT && state_nxt == boot_grant_pkg::ST_RUN) begin
			setup_r.context_reset <= 1'b0;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			count_r <= is_byte_boot(mode_s2_r) ? boot_grant_pkg::BOOT_WORD_COUNT : boot_grant_pkg::COUNT_RESET;
		end else if (i_byte_dma_word_done && count_r != boot_grant_pkg::COUNT_RESET) begin
			count_r <= count_r - 14'h0001;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= i_byte_dma_word_done && (count_r == 14'h0001);
		end
	end

	// Execution hold, context clear and host mode.
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			hold_r <= 1'b1;
			ctx_r <= 1'b0;
			host_r <= 1'b0;
		end else begin
			hold_r <= (state_nxt != boot_grant_pkg::ST_RUN);
			ctx_r <= (state_r == boot_grant_pkg::ST_BYTE_BOOT) && (state_nxt == boot_grant_pkg::ST_RUN);
			host_r <= (mode_r == boot_grant_pkg::MODE_BYTE_HOST) || (mode_r == boot_grant_pkg::MODE_HOST_PORT);
		end
	end

	// Bus grant, live through reset and boot.
	assign grant_ok = req_r && !i_ext_access_busy;

	always_ff @(posedge i_clock) begin
		if (!req_r) begin
			granted_r <= 1'b0;
		end else if (grant_ok) begin
			granted_r <= 1'b1;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!req_r) begin
			halt_r <= 1'b0;
			hang_r <= 1'b0;
		end else begin
			halt_r <= grant_ok && (!i_run_until_external || i_ext_access_wanted);
			hang_r <= (granted_r || grant_ok) && i_core_ready && i_ext_access_wanted;
		end
	end

	// Pin drivers, floated while granted.
	always_ff @(posedge i_clock) begin
		strobes_r <= i_core_strobes;
		strobes_oe_r <= !(req_r && (granted_r || grant_ok));
		bus_oe_r <= !(req_r && (granted_r || grant_ok)) && i_core_bus_drive;
		lsb_r <= i_byte_dma_addr_lsb;
		lsb_oe_r <= !(req_r && (granted_r || grant_ok)) && host_r && (count_r != boot_grant_pkg::COUNT_RESET);
	end

	assign o_ext_bus_grant_n = !granted_r;
	assign o_grant_hang_n = !hang_r;
	assign o_strobes = strobes_r;
	assign o_strobes_oe = strobes_oe_r;
	assign o_bus_oe = bus_oe_r;
	assign o_byte_dma_word_count = count_r;
	assign o_byte_dma_setup = setup_r;
	assign o_byte_dma_active = setup_r.context_reset;
	assign o_byte_dma_done_irq = irq_r;
	assign o_byte_addr_lsb = lsb_r;
	assign o_byte_addr_lsb_oe = lsb_oe_r;
	assign o_host_mode = host_r;
	assign o_exec_hold = hold_r;
	assign o_context_clear = ctx_r;
	assign o_core_halt = halt_r;
endmodule

// ==== sim/boot_grant_props.sv ====
// Port checker for the boot and bus grant block.
// Assumes it is bound to the top module on one clock.
`timescale 1ns/1ps
module boot_grant_props (
	input wire logic i_clock,
	input wire logic i_sys_rst,
	input wire logic i_ext_bus_req_n,
	input wire logic i_ext_access_busy,
	input wire logic i_ext_access_wanted,
	input wire logic i_run_until_external,
	input wire logic i_byte_dma_word_done,
	input wire logic o_ext_bus_grant_n,
	input wire logic o_grant_hang_n,
	input wire logic o_bus_oe,
	input wire logic o_strobes_oe,
	input wire logic o_core_halt,
	input wire logic [13:0] o_byte_dma_word_count,
	input wire logic o_byte_dma_done_irq
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_sys_rst);
	grant_req_a: assert property ($fell(o_ext_bus_grant_n) |-> !$past(i_ext_bus_req_n, 2)) else $error("no req");
	grant_busy_a: assert property ($fell(o_ext_bus_grant_n) |-> !$past(i_ext_access_busy)) else $error("busy");
	bus_float_a: assert property (!o_ext_bus_grant_n |-> !o_bus_oe && !o_strobes_oe) else $error("drive");
	grant_release_a: assert property ($rose(o_ext_bus_grant_n) |-> $past(i_ext_bus_req_n, 2)) else $error("rel");
	hang_grant_a: assert property (!o_grant_hang_n |-> !o_ext_bus_grant_n || !$past(o_ext_bus_grant_n)) else $error("hang");
	halt_grant_a: assert property ((!o_ext_bus_grant_n && !i_run_until_external) [*2] |-> o_core_halt) else $error("halt");
	run_on_a: assert property ((!o_ext_bus_grant_n && i_run_until_external && !i_ext_access_wanted) [*2] |-> !o_core_halt)
		else $error("run");
	count_dec_a: assert property (i_byte_dma_word_done && o_byte_dma_word_count != 14'h0000 |=>
		o_byte_dma_word_count == $past(o_byte_dma_word_count) - 14'h0001) else $error("count");
	irq_pulse_a: assert property (o_byte_dma_done_irq |-> o_byte_dma_word_count == 14'h0000 ##1 !o_byte_dma_done_irq) else $error("irq");
	grant_c: cover property ($fell(o_ext_bus_grant_n));
	hang_c: cover property (!o_grant_hang_n);
	irq_c: cover property (o_byte_dma_done_irq);
endmodule
bind boot_select_and_bus_grant boot_grant_props u_props (.i_clock, .i_sys_rst, .i_ext_bus_req_n, .i_ext_access_busy,
	.i_ext_access_wanted, .i_run_until_external, .i_byte_dma_word_done, .o_ext_bus_grant_n, .o_grant_hang_n,
	.o_bus_oe, .o_strobes_oe, .o_core_halt, .o_byte_dma_word_count, .o_byte_dma_done_irq);

// ==== sim/bus_master_model.sv ====
// External bus master that borrows the memory bus.
// Assumes the bench raises i_go to ask and lowers it to give back.
`timescale 1ns/1ps
module bus_master_model (
	// Clock and control.
	input wire logic i_clock,
	input wire logic i_go,
	// Handshake with the device.
	input wire logic i_grant_n,
	output logic o_req_n = 1'b1
);
	always @(posedge i_clock) begin
		if (o_req_n && i_go)
			o_req_n <= 1'b0;
		else if (!o_req_n && !i_grant_n && !i_go)
			o_req_n <= 1'b1;
	end
endmodule

// ==== sim/tb.sv ====
// Self-checking bench for boot selection and bus grant.
// Assumes the bus master model drives the request pin.
`timescale 1ns/1ps
module tb;
	logic clk = 0, rst = 1, go = 0, busy = 0, want = 0, rue = 0, rdy = 0, wd = 0, pm0 = 0;
	logic [2:0] mode = 3'h0;
	logic req_n, gnt_n, hang_n, soe, boe, act, irq, aoe, host, hold, cclr, halt;
	logic [13:0] cnt;
	boot_grant_pkg::byte_dma_setup_type setup;
	int fails = 0, compares = 0;
	initial forever #25 clk = ~clk;
	bus_master_model u_bm (.i_clock(clk), .i_go(go), .i_grant_n(gnt_n), .o_req_n(req_n));
	boot_select_and_bus_grant u_dut (.i_clock(clk), .i_sys_rst(rst), .i_mode_pins(mode),
		.i_ext_bus_req_n(req_n), .o_ext_bus_grant_n(gnt_n), .o_grant_hang_n(hang_n),
		.i_ext_access_busy(busy), .i_ext_access_wanted(want), .i_run_until_external(rue),
		.i_core_ready(rdy), .i_core_strobes('1), .i_core_bus_drive(1'b1), .o_strobes(),
		.o_strobes_oe(soe), .o_bus_oe(boe), .i_byte_dma_word_done(wd), .i_byte_dma_addr_lsb(1'b0),
		.i_pm0_written(pm0), .o_byte_dma_word_count(cnt), .o_byte_dma_setup(setup), .o_byte_dma_active(act),
		.o_byte_dma_done_irq(irq), .o_byte_addr_lsb(), .o_byte_addr_lsb_oe(aoe), .o_host_mode(host),
		.o_exec_hold(hold), .o_context_clear(cclr), .o_core_halt(halt));
	task automatic end_of_test;
		$display("fails %0d compares %0d", fails, compares);
		if (fails == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string n, input logic [13:0] s, input logic [13:0] e);
		compares++;
		if (s !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wt(ref logic s, input logic v);
		for (int i = 0; i < 40 && s !== v; i++) begin
			@(posedge clk);
			#1;
		end
		chk("wait", {13'h0000, s}, {13'h0000, v});
		if (s !== v)
			end_of_test();
	endtask
	task automatic boot(input logic [2:0] m);
		@(posedge clk);
		rst <= 1;
		mode <= m;
		repeat (8) @(posedge clk);
		rst <= 0;
		repeat (3) @(posedge clk);
		#1;
	endtask
	task automatic t_byte(input logic [2:0] m);
		@(posedge clk);
		rst <= 1;
		go <= 1;
		wt(gnt_n, 1'b0);
		@(posedge clk);
		go <= 0;
		wt(gnt_n, 1'b1);
		boot(m);
		chk("count", cnt, 14'h0020);
		chk("setup", {13'h0000, setup[39:1] != 39'h00_0000_0000}, 14'h0000);
		chk("active", act, 14'h0001);
		chk("hold", hold, 14'h0001);
		chk("host", host, m[2]);
		chk("lsb oe", aoe, m[2]);
		for (int i = 0; i < 31; i++) begin
			@(posedge clk);
			wd <= 1;
			@(posedge clk);
			wd <= 0;
		end
		repeat (2) @(posedge clk);
		#1;
		chk("count", cnt, 14'h0001);
		chk("irq", irq, 14'h0000);
		@(posedge clk);
		wd <= 1;
		@(posedge clk);
		wd <= 0;
		#1;
		chk("irq", irq, 14'h0001);
		chk("clear", cclr, 14'h0001);
		chk("active", act, 14'h0000);
		chk("count", cnt, 14'h0000);
		wt(hold, 1'b0);
	endtask
	task automatic t_host;
		boot(3'h5);
		chk("hold", hold, 14'h0001);
		chk("host", host, 14'h0001);
		@(posedge clk);
		pm0 <= 1;
		@(posedge clk);
		pm0 <= 0;
		wt(hold, 1'b0);
	endtask
	task automatic t_none(input logic [2:0] m);
		boot(m);
		chk("hold", hold, 14'h0000);
		chk("host", host, 14'h0000);
		chk("count", cnt, 14'h0000);
		@(posedge clk);
		mode <= 3'h5;
		repeat (4) @(posedge clk);
		#1;
		chk("host", host, 14'h0000);
		chk("hold", hold, 14'h0000);
	endtask
	task automatic t_grant;
		@(posedge clk);
		busy <= 1;
		go <= 1;
		repeat (10) @(posedge clk);
		#1;
		chk("grant", gnt_n, 14'h0001);
		@(posedge clk);
		busy <= 0;
		wt(gnt_n, 1'b0);
		repeat (2) @(posedge clk);
		#1;
		chk("bus oe", {13'h0000, boe | soe}, 14'h0000);
		chk("halt", halt, 14'h0001);
		@(posedge clk);
		rue <= 1;
		rdy <= 1;
		repeat (3) @(posedge clk);
		#1;
		chk("halt", halt, 14'h0000);
		@(posedge clk);
		want <= 1;
		wt(hang_n, 1'b0);
		wt(halt, 1'b1);
		@(posedge clk);
		go <= 0;
		wt(gnt_n, 1'b1);
		wt(hang_n, 1'b1);
		repeat (2) @(posedge clk);
		#1;
		chk("bus oe", boe, 14'h0001);
		chk("halt", halt, 14'h0000);
	endtask
	initial begin
		t_byte(3'h0);
		t_byte(3'h4);
		t_host;
		for (int i = 0; i < 8; i++)
			if (!(i inside {0, 4, 5}))
				t_none(3'(i));
		t_grant;
		end_of_test;
	end
endmodule
